/* logic/rss_consts.svh */
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
// instruction word width and opcode layout
`define RSS_IW 10
`define RSS_OP_RETURN_SKIP 10'h045
`define RSS_OP_SET_CARRY 10'h007
`define RSS_OP_SET_PORT 10'h015
`define RSS_OP_COMPARE_IMM 10'h025
`define RSS_OP_SECOND_HI 6'h07
// set-bit words sit at 0x00C..0x00F, clear of the set-carry word 0x007
`define RSS_OP_SETBIT_HI 8'h03
// widths
`define RSS_PCW 13
`define RSS_SPW 3
`define RSS_DPW 9
`define RSS_PORTW 8
`define RSS_SPDEPTH 8
`define RSS_YW 3
`define RSS_ONE_BIT 1'h1
`define RSS_RST_PC 13'h0000
`define RSS_RST_SP 3'h7
`endif

/* logic/rss_pkg.sv */
package rss_pkg;
  typedef struct packed {
    logic [12:0] pc;
    logic [2:0] sp;
    logic skip;
    logic carry;
  } rss_cpu_state_t;
  typedef enum logic [2:0] {
    RSS_FETCH = 3'h1,
    RSS_RET2 = 3'h2,
    RSS_IMM2 = 3'h4
  } rss_phase_t;
endpackage : rss_pkg

/* logic/rss_bitset.sv */
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_bitset (
  input wire logic [3:0] word_in, // current data word
  input wire logic [1:0] bit_sel, // bit index 0..3
  output logic [3:0] word_out // word with bit forced high
);
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_bit
      assign word_out[i] = word_in[i] | (bit_sel == i[1:0]);
    end
  endgenerate
endmodule : rss_bitset

/* logic/rss_return_skip_set_compare_ops.sv */
`timescale 1ns/1ps
`include "rss_consts.svh"
module rss_return_skip_set_compare_ops (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic reset, // sync, active high
  input wire logic instr_valid, // instruction word present
  input wire logic [9:0] instr, // fetched word
  input wire logic [3:0] accum, // accumulator value
  input wire logic [2:0] y_reg, // register Y
  input wire logic [8:0] data_pointer, // memory address
  input wire logic [3:0] mem_rdata, // M(data_pointer)
  input wire logic [12:0] stack_word, // return_stack entry at stack_pointer
  output logic [12:0] program_counter, // counter
  output logic [2:0] stack_pointer, // stack pointer
  output logic carry_flag, // carry
  output logic skip_next, // next word is skipped
  output logic mem_we, // memory write strobe
  output logic [8:0] mem_addr, // write address
  output logic [3:0] mem_wdata, // write data
  output logic [7:0] port_d, // port D latches
  output logic busy // second cycle in progress
);
  ////////////////////////////////////////////////////////////////////////
  rss_pkg::rss_cpu_state_t st_q, st_d;
  rss_pkg::rss_phase_t ph_q, ph_d;
  logic we_q, we_d;
  logic [8:0] addr_q, addr_d;
  logic [3:0] wd_q, wd_d;
  logic [7:0] port_q, port_d_d;
  logic [3:0] setword;
  logic is_bitset;
  logic busy_q, busy_d;
  logic take;

  assign is_bitset = instr[9:2] == `RSS_OP_SETBIT_HI;

  rss_bitset u_bitset (
    .word_in(mem_rdata),
    .bit_sel(instr[1:0]),
    .word_out(setword)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    we_d = 1'b0;
    addr_d = addr_q;
    wd_d = wd_q;
    port_d_d = port_q;
    case (ph_q)
      rss_pkg::RSS_FETCH: begin
        if (instr_valid) begin
          st_d.pc = st_q.pc + `RSS_PCW'(1);
          if (st_q.skip) begin
            st_d.skip = 1'b0;
          end else if (instr == `RSS_OP_RETURN_SKIP) begin
            st_d.pc = stack_word;
            st_d.sp = st_q.sp - `RSS_SPW'(1);
            ph_d = rss_pkg::RSS_RET2;
          end else if (instr == `RSS_OP_SET_CARRY) begin
            st_d.carry = `RSS_ONE_BIT;
          end else if (instr == `RSS_OP_SET_PORT) begin
            port_d_d[y_reg] = `RSS_ONE_BIT;
          end else if (instr == `RSS_OP_COMPARE_IMM) begin
            ph_d = rss_pkg::RSS_IMM2;
          end else if (is_bitset) begin
            we_d = 1'b1;
            addr_d = data_pointer;
            wd_d = setword;
          end
        end
      end
      rss_pkg::RSS_RET2: begin
        st_d.skip = 1'b1;
        ph_d = rss_pkg::RSS_FETCH;
      end
      rss_pkg::RSS_IMM2: begin
        if (instr_valid) begin
          st_d.pc = st_q.pc + `RSS_PCW'(1);
          st_d.skip = (instr[9:4] == `RSS_OP_SECOND_HI) && (accum == instr[3:0]);
          ph_d = rss_pkg::RSS_FETCH;
        end
      end
      default: ph_d = rss_pkg::RSS_FETCH;
    endcase
    busy_d = ph_d != rss_pkg::RSS_FETCH;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '{pc: `RSS_RST_PC, sp: `RSS_RST_SP, skip: 1'b0, carry: 1'b0};
      ph_q <= rss_pkg::RSS_FETCH;
      we_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
      port_q <= '0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      we_q <= we_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      port_q <= port_d_d;
      busy_q <= busy_d;
    end
  end

  assign program_counter = st_q.pc;
  assign stack_pointer = st_q.sp;
  assign carry_flag = st_q.carry;
  assign skip_next = st_q.skip;
  assign mem_we = we_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wd_q;
  assign port_d = port_q;
  assign busy = busy_q;

  ////////////////////////////////////////////////////////////////////////
  ret_pop_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ph_q == rss_pkg::RSS_FETCH && instr_valid && !st_q.skip && instr == `RSS_OP_RETURN_SKIP)
    |=> (stack_pointer == $past(stack_pointer) - 3'h1) && (program_counter == $past(stack_word))
    ##1 skip_next) else $error("return did not pop and skip");
  bit_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ph_q == rss_pkg::RSS_FETCH && instr_valid && !st_q.skip && is_bitset)
    |=> mem_we && mem_wdata[$past(instr[1:0])] && mem_addr == $past(data_pointer))
    else $error("memory bit not set");
  port_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ph_q == rss_pkg::RSS_FETCH && instr_valid && !st_q.skip && instr == `RSS_OP_SET_PORT)
    |=> port_d[$past(y_reg)] && $stable(carry_flag)) else $error("port bit not set");
  cmp_skip_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ph_q == rss_pkg::RSS_IMM2 && instr_valid && instr[9:4] == `RSS_OP_SECOND_HI)
    |=> (skip_next == ($past(accum) == $past(instr[3:0]))) && $stable(carry_flag))
    else $error("compare skip wrong");
  carry_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ph_q == rss_pkg::RSS_FETCH && instr_valid && !st_q.skip && instr == `RSS_OP_SET_CARRY)
    |=> carry_flag && !skip_next) else $error("carry not set");

  ////////////////////////////////////////////////////////////////////////
  // an instruction word is acted upon only when not being skipped
  assign take = ph_q == rss_pkg::RSS_FETCH && instr_valid && !st_q.skip;

  // a skipped word only advances the counter and clears the skip
  skip_consume_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ph_q == rss_pkg::RSS_FETCH && instr_valid && st_q.skip)
    |=> !skip_next && program_counter == $past(program_counter) + 13'h1
    && $stable(carry_flag) && $stable(stack_pointer))
    else $error("skipped word not consumed");

  // return occupies exactly two cycles
  ret_busy_a: assert property (@(posedge sys_clk) disable iff (reset)
    (take && instr == `RSS_OP_RETURN_SKIP)
    |=> busy ##1 !busy)
    else $error("return not two cycles");

  // the second return cycle holds the restored counter
  ret_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    (ph_q == rss_pkg::RSS_RET2)
    |=> program_counter == $past(program_counter))
    else $error("counter moved in return cycle");

  // only a return moves the stack pointer
  sp_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !(take && instr == `RSS_OP_RETURN_SKIP)
    |=> $stable(stack_pointer))
    else $error("stack pointer moved");

  // the write strobe follows only a taken set-bit word
  we_only_a: assert property (@(posedge sys_clk) disable iff (reset)
    !(take && is_bitset)
    |=> !mem_we)
    else $error("stray memory write");

  // set-port touches just the selected output
  port_only_a: assert property (@(posedge sys_clk) disable iff (reset)
    (take && instr == `RSS_OP_SET_PORT)
    |=> port_d == ($past(port_d) | (8'h01 << $past(y_reg))))
    else $error("other port bits changed");

  // compare waits a second cycle for its immediate word
  cmp_two_a: assert property (@(posedge sys_clk) disable iff (reset)
    (take && instr == `RSS_OP_COMPARE_IMM)
    |=> busy && $stable(carry_flag))
    else $error("compare not two words");
endmodule : rss_return_skip_set_compare_ops

/* testbench/rss_return_skip_set_compare_ops_test.sv */
`timescale 1ns/1ps
module rss_return_skip_set_compare_ops_test;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic instr_valid = 1'h0;
  logic [9:0] instr = 10'h000;
  logic [3:0] accum = 4'h5;
  logic [2:0] y_reg = 3'h0;
  logic [8:0] data_pointer = 9'h1A5;
  logic [3:0] mem_rdata = 4'h2;
  logic [12:0] stack_word = 13'h1ABC;
  logic [12:0] pc;
  logic [2:0] sp;
  logic cy, sk, we, bsy;
  logic [8:0] ma;
  logic [3:0] wd;
  logic [7:0] pd;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 sys_clk = ~sys_clk;
  rss_return_skip_set_compare_ops dut_u (.sys_clk(sys_clk), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .accum(accum), .y_reg(y_reg),
    .data_pointer(data_pointer), .mem_rdata(mem_rdata), .stack_word(stack_word),
    .program_counter(pc), .stack_pointer(sp), .carry_flag(cy), .skip_next(sk),
    .mem_we(we), .mem_addr(ma), .mem_wdata(wd), .port_d(pd), .busy(bsy));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input logic [9:0] w);
    @(negedge sys_clk);
    instr = w;
    instr_valid = 1'h1;
    @(negedge sys_clk);
    instr_valid = 1'h0;
  endtask : step
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic test_carry;
    step(10'h007);
    chk(13'(cy), 13'h1);
    chk(13'(sk), 13'h0);
    $display("set carry done");
  endtask : test_carry
  task automatic test_port;
    for (int y = 0; y < 8; y++) begin
      y_reg = 3'(y);
      step(10'h015);
      chk(13'(pd[y]), 13'h1);
    end
    chk(13'(cy), 13'h1);
    $display("set port done");
  endtask : test_port
  task automatic test_bit;
    for (int j = 0; j < 4; j++) begin
      step(10'h00C | 10'(j));
      chk(13'(we), 13'h1);
      chk(13'(ma), 13'h1A5);
      chk(13'(wd), 13'(4'h2 | (4'h1 << j)));
      chk(13'(cy), 13'h1);
      @(negedge sys_clk);
      chk(13'(we), 13'h0);
    end
    $display("set bit done");
  endtask : test_bit
  task automatic test_return;
    step(10'h045);
    chk(pc, 13'h1ABC);
    chk(13'(sp), 13'h6);
    chk(13'(bsy), 13'h1);
    @(negedge sys_clk);
    chk(13'(sk), 13'h1);
    chk(13'(bsy), 13'h0);
    step(10'h007);
    chk(13'(sk), 13'h0);
    chk(pc, 13'h1ABD);
    $display("return skip done");
  endtask : test_return
  task automatic test_compare;
    for (int n = 0; n < 16; n++) begin
      @(negedge sys_clk);
      instr = 10'h025;
      instr_valid = 1'h1;
      @(negedge sys_clk);
      instr = 10'h070 | 10'(n);
      @(negedge sys_clk);
      instr_valid = 1'h0;
      chk(13'(sk), 13'(n == 5));
      chk(13'(cy), 13'h1);
      if (n == 5) step(10'h000);
    end
    $display("compare done");
  endtask : test_compare
  ////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 1'h0;
    chk(pc, 13'h0000);
    chk(13'(sp), 13'h7);
    chk(13'(cy), 13'h0);
    chk(13'(pd), 13'h0);
    test_carry();
    test_port();
    test_bit();
    test_return();
    test_compare();
    conclude();
  end
endmodule : rss_return_skip_set_compare_ops_test
